//--- pkg/serial_port_pkg.sv
// Constants, register indices and carrier types for the serial port
// access gate and pin multiplexer.
// Assumes a 32-bit APB master and byte addresses of four times the index.
package serial_port_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_MCR = 12'h800;
  localparam logic [11:0] IDX_ASSIGN_LO = 12'h814;
  localparam logic [11:0] IDX_PDR = 12'h814;
  localparam logic [11:0] IDX_PARDDR = 12'h816;
  localparam logic [11:0] IDX_SC0 = 12'h818;
  localparam logic [11:0] IDX_SC1 = 12'h81A;
  localparam logic [11:0] IDX_SC2 = 12'h81C;
  localparam logic [11:0] IDX_RAM_LO = 12'h900;
  localparam logic [11:0] IDX_RAM_HI = 12'h94F;

  // Shared RAM: 80 bytes as 40 halfwords
  localparam int unsigned RAM_BYTES = 80;
  localparam int unsigned RAM_WORDS = RAM_BYTES / 2;
  localparam logic [5:0] RAM_RX_BASE = 6'h00;
  localparam logic [5:0] RAM_TX_BASE = 6'h10;
  localparam logic [5:0] RAM_CMD_BASE = 6'h20;

  // Values after reset
  localparam logic [15:0] MCR_RST = 16'h0080;
  localparam logic [15:0] PDR_RST = 16'h0000;
  localparam logic [15:0] PARDDR_RST = 16'h0000;
  localparam logic [15:0] SC0_RST = 16'h0104;
  localparam logic [15:0] SC1_RST = 16'h0404;
  localparam logic [15:0] SC2_RST = 16'h0000;

  // Implemented bits of each register
  localparam logic [15:0] MCR_MASK = 16'hE08F;
  localparam logic [15:0] PDR_MASK = 16'h001F;
  localparam logic [15:0] PARDDR_MASK = 16'h1B1F;
  localparam logic [15:0] SC0_MASK = 16'hFFFF;
  localparam logic [15:0] SC1_MASK = 16'hFFFF;
  localparam logic [15:0] SC2_MASK = 16'hEF0F;

  // Field positions
  localparam int unsigned MCR_PRIV_BIT = 7;
  localparam int unsigned SC0_MASTER_BIT = 15;
  localparam int unsigned SC0_WOR_BIT = 14;
  localparam int unsigned PAR_LSB = 8;
  localparam int unsigned NUM_PINS = 5;

  // Pin order: 0 master-in, 1 master-out, 2 clock, 3 select0/ss, 4 select1
  typedef struct packed {
    logic [4:0] level;
    logic [4:0] oe_n;
  } pin_drive_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RESP = 2'b10
  } bus_state_t;

endpackage : serial_port_pkg

//--- hw/serial_port_access_and_pin_mux.sv
// Privilege-gated register and RAM space plus five-pin function mux.
// Assumes an APB master on CORE_CLK_I, PPROT_I[0] high in supervisor
// state, and pins arriving asynchronously from outside.
//
// Functional notes
// - Global registers are reachable only in supervisor state.
// - Privilege bit set makes assignable space supervisor-only.
// - Denied reads return zero; denied writes change nothing.
// - Privilege bit clears only by a supervisor write.
// - Byte and word accesses work on every location; a long access reaches only the low word.
// - 80 bytes of RAM apart from registers, free bytes general use.
// - Serial logic uses separate receive, transmit and command regions.
// - Rewriting a value is harmless except for serial control two.
// - Five pins; unused ones serve as general-purpose port pins.
// - Master-in pin routed per mode and direction bit.
// - Master-out pin routed per mode and direction bit.
// - Clock pin routed per mode and direction bit.
// - Select-zero/slave-select routed per mode; master input may fault.
// - Select-one pin routed per mode and direction bit.
// - Pin function set by mode, assignment and direction bits.
// - Wired-OR bit makes all five pins open-drain.
// - Unimplemented bits ignore writes and read zero.
`timescale 1ns/1ps
module serial_port_access_and_pin_mux (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  input wire logic [2:0] PPROT_I,
  output logic PREADY_O,
  output logic [31:0] PRDATA_O,
  output logic PSLVERR_O,
  input wire logic [4:0] PIN_I,
  output serial_port_pkg::pin_drive_t PINS_O,
  input wire logic SER_DOUT_I,
  input wire logic SER_SCK_I,
  input wire logic [1:0] SER_PCS_I,
  output logic SER_DIN_O,
  output logic SER_SCK_IN_O,
  output logic SER_SS_N_O,
  output logic MODE_FAULT_O,
  output logic [15:0] SC0_O,
  output logic [15:0] SC1_O,
  output logic [15:0] SC2_O,
  output logic SC2_WR_O,
  input wire logic SER_RX_WE_I,
  input wire logic [3:0] SER_RX_IDX_I,
  input wire logic [15:0] SER_RX_DATA_I,
  input wire logic [3:0] SER_TX_IDX_I,
  output logic [15:0] SER_TX_DATA_O,
  input wire logic [3:0] SER_CMD_IDX_I,
  output logic [7:0] SER_CMD_O
);
  import serial_port_pkg::*;

  bus_state_t state_r;
  logic [15:0] mcr_r;
  logic [15:0] pdr_r;
  logic [15:0] parddr_r;
  logic [15:0] sc0_r;
  logic [15:0] sc1_r;
  logic [15:0] sc2_r;
  logic [15:0] ram [RAM_WORDS];
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;

  logic [11:0] idx;
  logic [11:0] ram_off;
  logic [5:0] ram_k;
  logic aligned;
  logic sup;
  logic priv;
  logic global_sp;
  logic is_ram;
  logic hit_mcr, hit_pdr, hit_parddr, hit_sc0, hit_sc1, hit_sc2;
  logic mapped;
  logic allowed;
  logic access;
  logic wr_fire;
  logic [15:0] rd_val;
  logic [15:0] pdr_view;

  logic master;
  logic wired_or_sel;
  logic [4:0] ddr;
  logic [4:0] par;
  logic [4:0] ser_val;
  logic [4:0] use_ser;
  logic [4:0] pin_val;
  pin_drive_t drive_nxt;

  // Byte-lane merge keeps unimplemented bits at zero
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] strb,
                                          input logic [15:0] mask);
    logic [15:0] m;
    m = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    return m & mask;
  endfunction : merge16

  // Address decode and privilege gate
  always_comb begin
    idx = PADDR_I[13:2];
    aligned = (PADDR_I[15:14] == 2'b00) && (PADDR_I[1:0] == 2'b00);
    sup = PPROT_I[0];
    priv = mcr_r[MCR_PRIV_BIT];
    global_sp = idx < IDX_ASSIGN_LO;
    ram_off = idx - IDX_RAM_LO;
    ram_k = ram_off[6:1];
    is_ram = aligned && (idx >= IDX_RAM_LO) && (idx <= IDX_RAM_HI)
             && !idx[0];
    hit_mcr = aligned && (idx == IDX_MCR);
    hit_pdr = aligned && (idx == IDX_PDR);
    hit_parddr = aligned && (idx == IDX_PARDDR);
    hit_sc0 = aligned && (idx == IDX_SC0);
    hit_sc1 = aligned && (idx == IDX_SC1);
    hit_sc2 = aligned && (idx == IDX_SC2);
    mapped = hit_mcr | hit_pdr | hit_parddr | hit_sc0 | hit_sc1
             | hit_sc2 | is_ram;
    allowed = global_sp ? sup : (sup | !priv);
    access = PSEL_I && PENABLE_I;
    wr_fire = (state_r == BUS_RESP) && access && PWRITE_I && allowed
              && mapped;
  end

  // Port data reads the pin for inputs, the latch for outputs
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pdr_view[i] = ddr[i] ? pdr_r[i] : pin_s2[i];
    end
    pdr_view[15:NUM_PINS] = '0;
  end

  always_comb begin
    rd_val = 16'h0000;
    if (allowed) begin
      if (hit_mcr) rd_val = mcr_r;
      else if (hit_pdr) rd_val = pdr_view;
      else if (hit_parddr) rd_val = parddr_r;
      else if (hit_sc0) rd_val = sc0_r;
      else if (hit_sc1) rd_val = sc1_r;
      else if (hit_sc2) rd_val = sc2_r;
      else if (is_ram) rd_val = ram[ram_k];
    end
  end

  // One wait state so read data comes from a flop
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_r <= BUS_IDLE;
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      case (state_r)
        BUS_IDLE: begin
          if (access) begin
            state_r <= BUS_RESP;
            PREADY_O <= 1'b1;
            PRDATA_O <= {16'h0000, rd_val};
            PSLVERR_O <= !mapped;
          end
        end
        BUS_RESP: begin
          state_r <= BUS_IDLE;
          PREADY_O <= 1'b0;
          PSLVERR_O <= 1'b0;
        end
        default: begin
          state_r <= BUS_IDLE;
          PREADY_O <= 1'b0;
          PSLVERR_O <= 1'b0;
        end
      endcase
    end
  end

  // Global configuration; only a supervisor reaches it at all
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mcr_r <= MCR_RST;
    end else if (wr_fire && hit_mcr) begin
      mcr_r <= merge16(mcr_r, PWDATA_I[15:0], PSTRB_I[1:0],
                       MCR_MASK);
    end
  end

  // Pin control registers
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pdr_r <= PDR_RST;
      parddr_r <= PARDDR_RST;
    end else begin
      if (wr_fire && hit_pdr) begin
        pdr_r <= merge16(pdr_r, PWDATA_I[15:0], PSTRB_I[1:0], PDR_MASK);
      end
      if (wr_fire && hit_parddr) begin
        parddr_r <= merge16(parddr_r, PWDATA_I[15:0], PSTRB_I[1:0],
                            PARDDR_MASK);
      end
    end
  end

  // Serial controls; changing them while enabled is software's risk
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sc0_r <= SC0_RST;
      sc1_r <= SC1_RST;
      sc2_r <= SC2_RST;
      SC2_WR_O <= 1'b0;
    end else begin
      if (wr_fire && hit_sc0) begin
        sc0_r <= merge16(sc0_r, PWDATA_I[15:0], PSTRB_I[1:0], SC0_MASK);
      end
      if (wr_fire && hit_sc1) begin
        sc1_r <= merge16(sc1_r, PWDATA_I[15:0], PSTRB_I[1:0],
                         SC1_MASK);
      end
      if (wr_fire && hit_sc2) begin
        sc2_r <= merge16(sc2_r, PWDATA_I[15:0], PSTRB_I[1:0], SC2_MASK);
      end
      // Any write here restarts the queue, even with the same value
      SC2_WR_O <= wr_fire && hit_sc2;
    end
  end

  assign SC0_O = sc0_r;
  assign SC1_O = sc1_r;
  assign SC2_O = sc2_r;

  // Shared RAM; a serial receive store wins a same-cycle collision
  always_ff @(posedge CORE_CLK_I) begin
    if (wr_fire && is_ram) begin
      ram[ram_k] <= merge16(ram[ram_k], PWDATA_I[15:0], PSTRB_I[1:0],
                            16'hFFFF);
    end
    if (SER_RX_WE_I) begin
      ram[RAM_RX_BASE + {2'b00, SER_RX_IDX_I}] <= SER_RX_DATA_I;
    end
  end

  logic [15:0] tx_word;
  logic [15:0] cmd_word;
  always_comb begin
    tx_word = ram[RAM_TX_BASE + {2'b00, SER_TX_IDX_I}];
    cmd_word = ram[RAM_CMD_BASE + {3'b000, SER_CMD_IDX_I[3:1]}];
  end

  // Even command byte is the high half of its word
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SER_TX_DATA_O <= 16'h0000;
      SER_CMD_O <= 8'h00;
    end else begin
      SER_TX_DATA_O <= tx_word;
      SER_CMD_O <= SER_CMD_IDX_I[0] ? cmd_word[7:0] : cmd_word[15:8];
    end
  end

  // Two-flop synchroniser for all five pins, clock pin included
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
    end else begin
      pin_s1 <= PIN_I;
      pin_s2 <= pin_s1;
    end
  end

  // Pin function select
  always_comb begin
    master = sc0_r[SC0_MASTER_BIT];
    wired_or_sel = sc0_r[SC0_WOR_BIT];
    ddr = parddr_r[NUM_PINS-1:0];
    // Clock pin has no assignment bit and serves the serial side unless a slave sets its direction bit
    par = {parddr_r[PAR_LSB+4], parddr_r[PAR_LSB+3], 1'b1,
           parddr_r[PAR_LSB+1], parddr_r[PAR_LSB]};
    ser_val = {SER_PCS_I[1], SER_PCS_I[0], SER_SCK_I, SER_DOUT_I,
               SER_DOUT_I};
    // Serial output in master mode except master-in, which is slave
    use_ser = par & {master, master, master, master, !master};
    // Otherwise the port data latch drives the pin
    pin_val = (use_ser & ser_val) | (~use_ser & pdr_r[4:0]);
    if (wired_or_sel) begin
      drive_nxt.level = 5'h00;
      drive_nxt.oe_n = ~(ddr & ~pin_val);
    end else begin
      drive_nxt.level = pin_val;
      drive_nxt.oe_n = ~ddr;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PINS_O <= '{level: 5'h00, oe_n: 5'h1F};
    end else begin
      PINS_O <= drive_nxt;
    end
  end

  // Inputs to the serial logic; idle values when not routed
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SER_DIN_O <= 1'b0;
      SER_SCK_IN_O <= 1'b0;
      SER_SS_N_O <= 1'b1;
      MODE_FAULT_O <= 1'b0;
    end else begin
      SER_DIN_O <= master ? (par[0] & !ddr[0] & pin_s2[0])
                          : (par[1] & !ddr[1] & pin_s2[1]);
      SER_SCK_IN_O <= !master && !ddr[2] && pin_s2[2];
      SER_SS_N_O <= (!master && !ddr[3] && par[3]) ? pin_s2[3]
                                                   : 1'b1;
      MODE_FAULT_O <= master && !ddr[3] && par[3] && !pin_s2[3];
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  logic resp_fire;
  assign resp_fire = (state_r == BUS_RESP) && access;

  property p_global_user_read;
    resp_fire && !PWRITE_I && !sup && global_sp |-> PRDATA_O == '0;
  endproperty
  a_global_user_read: assert property (p_global_user_read)
    else $error("User read of global space returned nonzero");

  property p_priv_user_read;
    resp_fire && !PWRITE_I && !sup && priv && !global_sp
      |-> PRDATA_O == '0;
  endproperty
  a_priv_user_read: assert property (p_priv_user_read)
    else $error("User read of restricted space returned nonzero");

  property p_user_write_ignored;
    resp_fire && PWRITE_I && !sup && priv && hit_sc0
      |=> sc0_r == $past(sc0_r);
  endproperty
  a_user_write_ignored: assert property (p_user_write_ignored)
    else $error("User write changed restricted register");

  property p_priv_clear;
    $fell(mcr_r[MCR_PRIV_BIT]) |-> $past(resp_fire && PWRITE_I && sup);
  endproperty
  a_priv_clear: assert property (p_priv_clear)
    else $error("Privilege bit cleared without supervisor write");

  property p_byte_lane;
    resp_fire && PWRITE_I && sup && hit_sc1 && PSTRB_I[1:0] == 2'b01
      |=> sc1_r[15:8] == $past(sc1_r[15:8])
          && sc1_r[7:0] == $past(PWDATA_I[7:0]);
  endproperty
  a_byte_lane: assert property (p_byte_lane)
    else $error("Byte write touched the wrong lane");

  property p_ram_store;
    resp_fire && PWRITE_I && allowed && is_ram && PSTRB_I[1:0] == 2'b11
      && !SER_RX_WE_I |=> ram[$past(ram_k)] == $past(PWDATA_I[15:0]);
  endproperty
  a_ram_store: assert property (p_ram_store)
    else $error("RAM word not stored");

  property p_sc2_pulse;
    resp_fire && PWRITE_I && sup && hit_sc2 |=> SC2_WR_O ##1 !SC2_WR_O;
  endproperty
  a_sc2_pulse: assert property (p_sc2_pulse)
    else $error("Control two write gave no single pulse");

  property p_open_drain;
    $past(wired_or_sel) |-> PINS_O.level == 5'h00;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("Pin driven high in wired-OR mode");

  property p_dir_enable;
    !$past(wired_or_sel) |-> PINS_O.oe_n == ~$past(ddr);
  endproperty
  a_dir_enable: assert property (p_dir_enable)
    else $error("Pin enable does not follow direction bit");

  property p_gp_drive;
    !$past(wired_or_sel) && $past(ddr[4] && !par[4]) |-> PINS_O.level[4]
      == $past(pdr_r[4]);
  endproperty
  a_gp_drive: assert property (p_gp_drive)
    else $error("General-purpose pin not driving port data");

  property p_mode_fault;
    master && !ddr[3] && par[3] && !pin_s2[3] |=> MODE_FAULT_O;
  endproperty
  a_mode_fault: assert property (p_mode_fault)
    else $error("Low select input in master mode raised no fault");

  c_user_denied: cover property (resp_fire && !sup && !allowed);
  c_sc2_write: cover property (SC2_WR_O);
  c_mode_fault: cover property (MODE_FAULT_O);
  c_ram_write: cover property (wr_fire && is_ram);

endmodule : serial_port_access_and_pin_mux

//--- verification/serial_far_end.sv
// Far-side model of the five serial pins: a peripheral or another master.
// Assumes pull-ups on every pin, so a released line reads high.
`timescale 1ns/1ps
module serial_far_end
  import serial_port_pkg::*;
(
  input wire serial_port_pkg::pin_drive_t PINS_I,
  input wire logic [4:0] DRIVE_EN_I,
  input wire logic [4:0] DRIVE_VAL_I,
  input wire logic LINK_RUN_I,
  output logic [4:0] PIN_O
);
  logic link_sck = 1'b0;

  // Link clock stands still at 0 between frames
  always begin
    #40;
    link_sck = LINK_RUN_I ? ~link_sck : 1'b0;
  end

  // Wire level from both parties; a contention is a bench fault
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!PINS_I.oe_n[i])
        PIN_O[i] = PINS_I.level[i];
      else if (DRIVE_EN_I[i])
        PIN_O[i] = (i == 2 && LINK_RUN_I) ? link_sck : DRIVE_VAL_I[i];
      else
        PIN_O[i] = 1'b1;
    end
  end
endmodule : serial_far_end

//--- verification/test_serial_port_access_and_pin_mux.sv
// Self-checking bench for the access gate and pin multiplexer.
// Assumes the package and the far-end pin model are compiled first.
`timescale 1ns/1ps
module test_serial_port_access_and_pin_mux;
  import serial_port_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [15:0] paddr = 16'h0000, rxdat = 16'h0000, sc0, sc1, sc2, txdat, v;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic [3:0] pstrb = 4'h0, rxidx = 4'h0, txidx = 4'h0, cmdidx = 4'h0;
  logic [2:0] pprot = 3'h0;
  logic pready, pslverr, din, sckin, ssn, mfault, sc2wr, sckp;
  logic dout = 1'b0, sck = 1'b0, rxwe = 1'b0, frun = 1'b0;
  logic [4:0] pin, fen = 5'h00, fval = 5'h00;
  logic [1:0] pcs = 2'h0;
  logic [7:0] cmd;
  logic [17:0] e;
  logic [17:0] expq[$];
  pin_drive_t pins;
  int n_mismatch = 0, checks_done = 0, sc2_pulses = 0, edges, p;
  int unsigned rnd;
  int ks[4] = '{0, 17, 39, 5};

  serial_port_access_and_pin_mux i_dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb),
    .PPROT_I(pprot), .PREADY_O(pready), .PRDATA_O(prdata),
    .PSLVERR_O(pslverr), .PIN_I(pin), .PINS_O(pins), .SER_DOUT_I(dout),
    .SER_SCK_I(sck), .SER_PCS_I(pcs), .SER_DIN_O(din),
    .SER_SCK_IN_O(sckin), .SER_SS_N_O(ssn), .MODE_FAULT_O(mfault),
    .SC0_O(sc0), .SC1_O(sc1), .SC2_O(sc2), .SC2_WR_O(sc2wr),
    .SER_RX_WE_I(rxwe), .SER_RX_IDX_I(rxidx), .SER_RX_DATA_I(rxdat),
    .SER_TX_IDX_I(txidx), .SER_TX_DATA_O(txdat), .SER_CMD_IDX_I(cmdidx),
    .SER_CMD_O(cmd)
  );

  serial_far_end i_far (
    .PINS_I(pins), .DRIVE_EN_I(fen), .DRIVE_VAL_I(fval),
    .LINK_RUN_I(frun), .PIN_O(pin)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Request held until pready is sampled high at a rising edge
  task automatic apb(logic w, logic [11:0] idx, logic [15:0] d,
      logic [1:0] st, logic sup, logic err);
    int n;
    n = 0;
    expq.push_back({~w, err, w ? 16'h0000 : d});
    psel <= 1'b1;
    pwr <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, d};
    pstrb <= {2'b00, st};
    pprot <= {2'b00, sup};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      give_verdict();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(logic [11:0] idx, logic [15:0] d,
      logic [1:0] st = 2'b11, logic sup = 1'b1);
    apb(1'b1, idx, d, st, sup, 1'b0);
  endtask : wr

  task automatic rd(logic [11:0] idx, logic [15:0] d, logic sup = 1'b1);
    apb(1'b0, idx, d, 2'b11, sup, 1'b0);
  endtask : rd

  task automatic settle();
    repeat (4) @(posedge clk);
  endtask : settle

  // Oldest note against each answer; upper half must read zero
  always @(negedge clk) begin
    if (pready === 1'b1) begin
      e = expq.pop_front();
      chk("pslverr", {31'h0, e[16]}, {31'h0, pslverr});
      if (e[17])
        chk("prdata", {16'h0000, e[15:0]}, prdata);
    end
    if (sc2wr === 1'b1)
      sc2_pulses++;
  end

  initial begin
    #300000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    rnd = $urandom(68);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(IDX_MCR, MCR_RST);
    rd(IDX_SC0, SC0_RST);
    rd(IDX_SC1, SC1_RST);
    rd(IDX_SC2, SC2_RST);
    wr(IDX_PARDDR, 16'hFFFF);
    rd(IDX_PARDDR, PARDDR_MASK);
    wr(IDX_SC2, 16'hFFFF);
    rd(IDX_SC2, SC2_MASK);
    chk("sc2 copy", {16'h0000, SC2_MASK}, {16'h0000, sc2});
    apb(1'b0, 12'h802, 16'h0000, 2'b11, 1'b1, 1'b1);
    $display("test reset_and_masks done");
    rd(IDX_MCR, 16'h0000, 1'b0);
    wr(IDX_MCR, 16'h0000, 2'b11, 1'b0);
    rd(IDX_MCR, MCR_RST);
    wr(IDX_SC1, 16'h1234, 2'b11, 1'b0);
    rd(IDX_SC1, 16'h0000, 1'b0);
    rd(IDX_SC1, SC1_RST);
    wr(IDX_SC0, 16'h1234, 2'b11, 1'b0);
    rd(IDX_SC0, SC0_RST);
    chk("sc0 copy", {16'h0000, SC0_RST}, {16'h0000, sc0});
    wr(IDX_MCR, 16'h0000);
    wr(IDX_SC1, 16'h1234, 2'b11, 1'b0);
    rd(IDX_SC1, 16'h1234, 1'b0);
    chk("sc1 copy", 32'h0000_1234, {16'h0000, sc1});
    wr(IDX_SC1, 16'hFFAB, 2'b01);
    rd(IDX_SC1, 16'h12AB);
    $display("test privilege done");
    foreach (ks[j]) begin
      v = 16'($urandom());
      // RAM word k sits at index base plus 2k
      wr(IDX_RAM_LO + 12'(2 * ks[j]), v, 2'b11, 1'b0);
      rd(IDX_RAM_LO + 12'(2 * ks[j]), v, 1'b0);
    end
    wr(IDX_RAM_LO + 12'h04E, 16'hAA55);
    wr(IDX_RAM_LO + 12'h04E, 16'h1122, 2'b10);
    wr(IDX_RAM_LO + 12'h04E, 16'h9933, 2'b01);
    rd(IDX_RAM_LO + 12'h04E, 16'h1133);
    v = 16'($urandom());
    rxidx <= 4'h3;
    rxdat <= v;
    rxwe <= 1'b1;
    @(posedge clk);
    rxwe <= 1'b0;
    rd(IDX_RAM_LO + 12'h006, v);
    wr(IDX_RAM_LO + 12'h02A, 16'h5A3C);
    wr(IDX_RAM_LO + 12'h040, 16'hA1B2);
    txidx <= 4'h5;
    cmdidx <= 4'h1;
    settle();
    chk("tx word", 32'h0000_5A3C, {16'h0000, txdat});
    chk("cmd byte", 32'h0000_00B2, {24'h0, cmd});
    p = sc2_pulses;
    wr(IDX_SC2, 16'h0000);
    wr(IDX_SC2, 16'h0000);
    chk("sc2 pulses", 32'(p + 2), 32'(sc2_pulses));
    $display("test ram done");
    // Master: pins 0,1,3 assigned, pins 1 and 2 driven, 0 and 3 inputs
    fval <= 5'(($urandom() & 32'h1) | 32'h10);
    fen <= 5'b01001;
    dout <= 1'b1;
    sck <= 1'b1;
    pcs <= 2'b10;
    // Serial unit stays disabled while its controls change
    wr(IDX_SC0, 16'h8104);
    wr(IDX_PARDDR, 16'h0B06);
    settle();
    chk("mosi out", 32'h0000_0002, {30'h0, pins.level[1], pins.oe_n[1]});
    chk("sck out", 32'h0000_0002, {30'h0, pins.level[2], pins.oe_n[2]});
    chk("miso in", {31'h0, fval[0]}, {31'h0, din});
    chk("mode fault", 32'h0000_0001, {31'h0, mfault});
    fen <= 5'b00001;
    wr(IDX_PARDDR, 16'h0B1E);
    wr(IDX_PDR, 16'h0010);
    settle();
    chk("no fault", 32'h0000_0000, {31'h0, mfault});
    chk("sel0 out", 32'h0000_0000, {30'h0, pins.level[3], pins.oe_n[3]});
    chk("gp out", 32'h0000_0002, {30'h0, pins.level[4], pins.oe_n[4]});
    $display("test master pins done");
    // Slave: all inputs, far end runs the link clock on pin 2
    fval <= 5'(($urandom() & 32'h7) | 32'h10);
    fen <= 5'b01111;
    wr(IDX_SC0, 16'h0104);
    wr(IDX_PARDDR, 16'h0B00);
    frun <= 1'b1;
    settle();
    chk("mosi in", {31'h0, fval[1]}, {31'h0, din});
    chk("ss in", 32'h0000_0000, {31'h0, ssn});
    edges = 0;
    sckp = sckin;
    repeat (40) begin
      @(posedge clk);
      if (sckin !== sckp)
        edges++;
      sckp = sckin;
    end
    chk("sck edges", 32'h0000_0001, {31'h0, edges >= 8 && edges <= 11});
    frun <= 1'b0;
    fen <= 5'b00111;
    settle();
    rd(IDX_PDR, {11'h0, 2'b11, fval[2:0]});
    $display("test slave pins done");
    fen <= 5'b00000;
    dout <= 1'b1;
    wr(IDX_SC0, 16'hC104);
    wr(IDX_PARDDR, 16'h0B06);
    settle();
    chk("od release", 32'h0000_0001, {30'h0, pins.level[1], pins.oe_n[1]});
    chk("od pull-up", 32'h0000_0001, {31'h0, pin[1]});
    dout <= 1'b0;
    settle();
    chk("od low", 32'h0000_0000, {30'h0, pins.level[1], pins.oe_n[1]});
    $display("test open drain done");
    give_verdict();
  end
endmodule : test_serial_port_access_and_pin_mux
